// ===== hw/modsel_pkg.sv
/*
 * Types shared by the modulator test input select block.
 * Assumes the constants header is compiled alongside.
 */
package modsel_pkg;

typedef enum logic [1:0] {
	GAIN_X1 = 2'h1,
	GAIN_X2_MODE = 2'h2,
	GAIN_BAD = 2'h3
} gain_mode_e;

typedef struct packed {
	logic [31:0] addr;
	logic [31:0] data;
	logic [3:0] strb;
} wr_req_s;

typedef struct packed {
	logic [9:0] pos_val;
	logic [9:0] neg_val;
	logic pos_en;
	logic neg_en;
} dac_drive_s;

typedef logic [1:0] mul_t;

endpackage : modsel_pkg

// ===== hw/modsel_regs.svh
/*
 * Register offsets, field positions and reset values of the modulator test input select block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`ifndef MODSEL_REGS_SVH
`define MODSEL_REGS_SVH

`define OFF_CH_SEL 8'h00
`define OFF_GAIN_LO 8'h04
`define OFF_DAC_CTRL 8'h08
`define OFF_EXT_CTRL 8'h0C
`define OFF_DAC_VAL 8'h10
`define OFF_STATUS 8'h14

`define GAIN_W 3
`define GAIN_FIELD_W 4
`define NUM_CH 7
`define NUM_DIFF 4

`define DAC_MASTER_BIT 0
`define DAC_OE0_BIT 1
`define DAC_OE1_BIT 2
`define EXT_PIN_OUT_BIT 0
`define EXT_OUT_DIS_BIT 1

`define RST_CH_SEL 7'h00
`define RST_GAIN 28'h0000000
`define RST_DAC_CTRL 3'h0
`define RST_EXT_CTRL 2'h0
`define RST_DAC_VAL 10'h000

`define GAIN_X2 3'h5
`define GAIN_X4 3'h6
`define GAIN_UNITY_MAX 3'h3

`endif

// ===== hw/modsel_top.sv
/*
 * Modulator test input select: per-channel routing of DAC outputs to the modulators,
 * DAC output gating and test-mode gain decode, behind an AXI4-Lite slave.
 * Assumes one clock, asynchronous active-low reset, and a well-behaved AXI master.
 */
`timescale 1ns/100ps
`include "modsel_regs.svh"

// Operation
// - Select bit routes DAC to modulator, ignores pins
// - DAC-to-modulator output only when any select set
// - Output-disable overrides per-channel DAC output enables
// - Test gain: 000-011 unity, 101 x2, 110 x4 on channels 0-3; channels 4-6 take 000-010 unity only
// - DAC ch1 positive input, ch0 negative input
// - Disabled DAC channel drives constant low
module modsel_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic [9:0] dac_ch0_code,
	input wire logic [9:0] dac_ch1_code,
	output logic [`NUM_CH-1:0] mod_src_dac,
	output logic [`NUM_CH-1:0] mod_src_pin,
	output modsel_pkg::dac_drive_s dac_drive,
	output logic dac_mod_path_en,
	output logic analog_pin_out_en,
	output modsel_pkg::mul_t [`NUM_CH-1:0] mod_gain_mult,
	output logic [`NUM_CH-1:0] mod_gain_bad
);
	import modsel_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [`NUM_CH-1:0] channel_input_select_reg_r;
	logic [`NUM_CH*`GAIN_FIELD_W-1:0] channel_gain_select_reg_r;
	logic [2:0] dac_control_reg_r;
	logic [1:0] converter_control_ext_reg_r;

	logic aw_held_r;
	logic w_held_r;
	logic [31:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	wire aw_fire = s_awvalid && s_awready;
	wire w_fire = s_wvalid && s_wready;
	wire ar_fire = s_arvalid && s_arready;
	wire wr_go = aw_held_r && w_held_r && !bvalid_r;
	wire [7:0] wr_off = aw_addr_r[7:0];
	wire wr_map_hit = (aw_addr_r[31:8] == 24'h000000) && (wr_off <= `OFF_EXT_CTRL)
		&& (wr_off[1:0] == 2'h0);
	wire wr_sel = wr_go && wr_map_hit && (wr_off == `OFF_CH_SEL) && w_strb_r[0];
	wire wr_gain = wr_go && wr_map_hit && (wr_off == `OFF_GAIN_LO);
	wire wr_dac = wr_go && wr_map_hit && (wr_off == `OFF_DAC_CTRL) && w_strb_r[0];
	wire wr_ext = wr_go && wr_map_hit && (wr_off == `OFF_EXT_CTRL) && w_strb_r[0];

	assign s_awready = !aw_held_r;
	assign s_wready = !w_held_r;
	assign s_arready = !rvalid_r;
	assign s_bvalid = bvalid_r;
	assign s_bresp = bresp_r;
	assign s_rvalid = rvalid_r;
	assign s_rdata = rdata_r;
	assign s_rresp = rresp_r;

	////////////////////////////////////////////////////////////////////////////
	// Write channel
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 32'h00000000;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else begin
			if (aw_fire) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_awaddr;
			end else if (wr_go) begin
				aw_held_r <= 1'b0;
			end
			if (w_fire) begin
				w_held_r <= 1'b1;
				w_data_r <= s_wdata;
				w_strb_r <= s_wstrb;
			end else if (wr_go) begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_map_hit ? 2'h0 : 2'h2;
		end else if (s_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Gain field write honours byte lanes
	logic [31:0] gain_wr_mask;
	always_comb begin
		gain_wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			channel_input_select_reg_r <= `RST_CH_SEL;
			channel_gain_select_reg_r <= `RST_GAIN;
			dac_control_reg_r <= `RST_DAC_CTRL;
			converter_control_ext_reg_r <= `RST_EXT_CTRL;
		end else begin
			if (wr_sel)
				channel_input_select_reg_r <= w_data_r[`NUM_CH-1:0];
			if (wr_gain)
				channel_gain_select_reg_r <= (channel_gain_select_reg_r & ~gain_wr_mask[27:0])
					| (w_data_r[27:0] & gain_wr_mask[27:0]);
			if (wr_dac)
				dac_control_reg_r <= w_data_r[2:0];
			if (wr_ext)
				converter_control_ext_reg_r <= w_data_r[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Test-mode datapath
	wire any_sel = |channel_input_select_reg_r;
	wire out_dis = converter_control_ext_reg_r[`EXT_OUT_DIS_BIT];
	wire master_en = dac_control_reg_r[`DAC_MASTER_BIT];
	wire oe0 = dac_control_reg_r[`DAC_OE0_BIT];
	wire oe1 = dac_control_reg_r[`DAC_OE1_BIT];
	wire ch0_on = any_sel && !out_dis && (master_en || oe0);
	wire ch1_on = any_sel && !out_dis && (master_en || oe1);
	wire usable = master_en || (oe0 && oe1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mod_src_dac <= `RST_CH_SEL;
			mod_src_pin <= {`NUM_CH{1'b1}};
			dac_drive <= '0;
			dac_mod_path_en <= 1'b0;
			analog_pin_out_en <= 1'b0;
		end else begin
			mod_src_dac <= channel_input_select_reg_r;
			mod_src_pin <= ~channel_input_select_reg_r;
			dac_mod_path_en <= ch0_on || ch1_on;
			dac_drive.pos_en <= ch1_on;
			dac_drive.neg_en <= ch0_on;
			dac_drive.pos_val <= ch1_on ? dac_ch1_code : 10'h000;
			dac_drive.neg_val <= ch0_on ? dac_ch0_code : 10'h000;
			analog_pin_out_en <= converter_control_ext_reg_r[`EXT_PIN_OUT_BIT];
		end
	end

	// Per-channel gain decode; prohibited codes keep unity and raise the flag
	mul_t [`NUM_CH-1:0] gain_mult_nxt;
	logic [`NUM_CH-1:0] gain_bad_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CH; gi++) begin : g_gain
			wire [`GAIN_W-1:0] code = channel_gain_select_reg_r[gi*`GAIN_FIELD_W +: `GAIN_W];
			if (gi >= `NUM_DIFF) begin : g_single
				// Single-ended: unity only, codes 000-010 of the three-bit field
				assign gain_mult_nxt[gi] = 2'h0;
				assign gain_bad_nxt[gi] = code[2] || (code[1:0] == 2'h3);
			end else begin : g_diff
				wire is_x2 = (code == `GAIN_X2);
				wire is_x4 = (code == `GAIN_X4);
				assign gain_mult_nxt[gi] = is_x4 ? 2'h2 : (is_x2 ? 2'h1 : 2'h0);
				assign gain_bad_nxt[gi] = (code > `GAIN_UNITY_MAX) && !is_x2 && !is_x4;
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mod_gain_mult <= '0;
			mod_gain_bad <= '0;
		end else begin
			mod_gain_mult <= gain_mult_nxt;
			mod_gain_bad <= gain_bad_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel
	logic [31:0] rd_mux;
	wire [7:0] rd_off = s_araddr[7:0];
	wire rd_hit = (s_araddr[31:8] == 24'h000000) && (rd_off <= `OFF_STATUS)
		&& (rd_off[1:0] == 2'h0);
	always_comb begin
		case (rd_off)
			`OFF_CH_SEL: rd_mux = {25'h0000000, channel_input_select_reg_r};
			`OFF_GAIN_LO: rd_mux = {4'h0, channel_gain_select_reg_r};
			`OFF_DAC_CTRL: rd_mux = {29'h00000000, dac_control_reg_r};
			`OFF_EXT_CTRL: rd_mux = {30'h00000000, converter_control_ext_reg_r};
			`OFF_DAC_VAL: rd_mux = {6'h00, dac_ch1_code, 6'h00, dac_ch0_code};
			`OFF_STATUS: rd_mux = {28'h0000000, usable, ch1_on, ch0_on, any_sel};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'h0;
		end else if (ar_fire) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_hit ? rd_mux : 32'h00000000;
			rresp_r <= rd_hit ? 2'h0 : 2'h2;
		end else if (s_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_PIN_SRC: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> (mod_src_pin == ~$past(channel_input_select_reg_r)))
		else $error("pin source not complement of select");
	AST_DAC_NEEDS_SEL: assert property (@(posedge clk) disable iff (!rst_b)
		!any_sel |=> !dac_mod_path_en)
		else $error("dac path enabled without select");
	AST_DIS_WINS: assert property (@(posedge clk) disable iff (!rst_b)
		out_dis |=> !dac_drive.pos_en && !dac_drive.neg_en)
		else $error("output disable did not override");
	AST_USABLE: assert property (@(posedge clk) disable iff (!rst_b)
		usable && any_sel && !out_dis
		|=> dac_drive.pos_en && dac_drive.neg_en)
		else $error("usable setting did not enable both channels");
	AST_PIN_OUT: assert property (@(posedge clk) disable iff (!rst_b)
		wr_ext ##1 1'b1 |=> analog_pin_out_en == $past(w_data_r[0], 2))
		else $error("pin output control not applied");
	AST_GAIN2: assert property (@(posedge clk) disable iff (!rst_b)
		(channel_gain_select_reg_r[2:0] == 3'h5) |=> mod_gain_mult[0] == 2'h1)
		else $error("gain x2 decode wrong");
	AST_POS_SRC: assert property (@(posedge clk) disable iff (!rst_b)
		ch1_on |=> dac_drive.pos_val == $past(dac_ch1_code))
		else $error("positive input not from channel 1");
	AST_LOW_OFF: assert property (@(posedge clk) disable iff (!rst_b)
		!ch0_on |=> dac_drive.neg_val == 10'h000)
		else $error("disabled channel not low");
	AST_NO_SEL: assert property (@(posedge clk) disable iff (!rst_b)
		(channel_input_select_reg_r == 7'h00) [*2] |-> mod_src_pin == 7'h7F)
		else $error("pins not selected with no select");

	// Routing of all channels, gating, and gain decode on channels 0 and 6
	AST_SRC_DAC: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> (mod_src_dac == $past(channel_input_select_reg_r)))
		else $error("dac source not equal to select");
	AST_DAC_SEL: assert property (@(posedge clk) disable iff (!rst_b)
		any_sel && !out_dis && master_en
		|=> dac_mod_path_en)
		else $error("dac path not enabled with select set");
	AST_DIS_PATH: assert property (@(posedge clk) disable iff (!rst_b)
		out_dis |=> !dac_mod_path_en)
		else $error("output disable left dac path on");
	AST_GAIN4: assert property (@(posedge clk) disable iff (!rst_b)
		(channel_gain_select_reg_r[2:0] == 3'h6) |=> mod_gain_mult[0] == 2'h2)
		else $error("gain x4 decode wrong");
	AST_GAIN_UNITY: assert property (@(posedge clk) disable iff (!rst_b)
		(channel_gain_select_reg_r[2:0] <= 3'h3) |=> (mod_gain_mult[0] == 2'h0) && !mod_gain_bad[0])
		else $error("unity gain decode wrong");
	AST_SINGLE_OK: assert property (@(posedge clk) disable iff (!rst_b)
		(channel_gain_select_reg_r[26:24] <= 3'h2) |=> (mod_gain_mult[6] == 2'h0) && !mod_gain_bad[6])
		else $error("single-ended unity decode wrong");
	AST_NEG_SRC: assert property (@(posedge clk) disable iff (!rst_b)
		ch0_on |=> dac_drive.neg_val == $past(dac_ch0_code))
		else $error("negative input not from channel 0");
	AST_POS_LOW: assert property (@(posedge clk) disable iff (!rst_b)
		!ch1_on |=> dac_drive.pos_val == 10'h000)
		else $error("disabled positive channel not low");
	AST_NO_SEL_OFF: assert property (@(posedge clk) disable iff (!rst_b)
		!any_sel |=> !dac_drive.pos_en && !dac_drive.neg_en)
		else $error("dac drive enabled with no select");

endmodule : modsel_top

// ===== sim/dac_model.sv
/*
 * Far-side model: on-chip DAC holding two channel codes.
 * Assumes the bench loads the value inputs; codes follow one clock later.
 */
`timescale 1ns/100ps
module dac_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [9:0] v0,
	input wire logic [9:0] v1,
	output logic [9:0] code0,
	output logic [9:0] code1
);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			code0 <= 10'h000;
			code1 <= 10'h000;
		end else begin
			code0 <= v0;
			code1 <= v1;
		end
	end
endmodule : dac_model

// ===== sim/testbench.sv
/*
 * Self-checking bench for the modulator test input select block.
 * Assumes the register header and package are compiled first.
 */
`timescale 1ns/100ps
`include "modsel_regs.svh"
module testbench;
import modsel_pkg::*;
logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
logic awready, wready, bvalid, arready, rvalid, path_en, pin_en, b;
logic [31:0] awaddr, wdata, araddr, rdata, d;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, r;
logic [9:0] c0, c1, v0, v1;
logic [6:0] src_dac, src_pin, gbad, s;
logic [2:0] dc, g;
logic [1:0] ex;
dac_drive_s drv;
mul_t [6:0] gmul;
int num_errors, n_compared;
////////////////////////////////////////
modsel_top modsel_top_inst(.clk, .rst_b, .s_awaddr(awaddr), .s_awvalid(awvalid),
	.s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
	.s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
	.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
	.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .dac_ch0_code(c0),
	.dac_ch1_code(c1), .mod_src_dac(src_dac), .mod_src_pin(src_pin), .dac_drive(drv),
	.dac_mod_path_en(path_en), .analog_pin_out_en(pin_en), .mod_gain_mult(gmul),
	.mod_gain_bad(gbad));
dac_model dac_model_inst(.clk, .rst_b, .v0, .v1, .code0(c0), .code1(c1));
////////////////////////////////////////
initial begin clk = 1'b0; forever #4 clk = ~clk; end
initial begin #160000; num_errors++; finish_test(); end
task chk(input logic [31:0] got, input logic [31:0] exp);
	n_compared++;
	if (got !== exp) begin
		num_errors++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask : chk
task wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
	@(posedge clk);
	awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
	do begin
		@(posedge clk);
		if (awready) awvalid <= 1'b0;
		if (wready) wvalid <= 1'b0;
	end while (!bvalid);
	rs = bresp;
	bready <= 1'b0;
endtask : wr
task rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
	@(posedge clk);
	araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
	do begin
		@(posedge clk);
		if (arready) arvalid <= 1'b0;
	end while (!rvalid);
	v = rdata; rs = rresp;
	rready <= 1'b0;
endtask : rd
function automatic logic [22:0] exp_drv(logic [6:0] sl, logic [2:0] c, logic [1:0] e,
	logic [9:0] a0, logic [9:0] a1);
	logic on, pe, ne;
	on = |sl & !e[1];
	pe = on & (c[0] | c[2]);
	ne = on & (c[0] | c[1]);
	return {pe | ne, pe ? a1 : 10'h000, ne ? a0 : 10'h000, pe, ne};
endfunction : exp_drv
function automatic logic [3:0] exp_stat(logic [6:0] sl, logic [2:0] c, logic [1:0] e);
	logic on;
	on = |sl & !e[1];
	return {c[0] | (c[1] & c[2]), on & (c[0] | c[2]), on & (c[0] | c[1]), |sl};
endfunction : exp_stat
task finish_test;
	$display("Compared %0d, errors %0d", n_compared, num_errors);
	if (num_errors == 0 && n_compared > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
endtask : finish_test
////////////////////////////////////////
initial begin
	rst_b = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
	rready = 1'b0; awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0; wstrb = 4'hF;
	v0 = 10'h000; v1 = 10'h000;
	void'($urandom(72));
	repeat (4) @(posedge clk);
	chk(src_pin, 7'h7F);
	chk(path_en, 1'b0);
	rst_b <= 1'b1;
	for (int i = 0; i < 40; i++) begin
		s = 7'($urandom); dc = 3'($urandom); ex = 2'($urandom);
		if (i == 0) begin s = 7'h7F; dc = 3'h6; ex = 2'h0; end
		if (i == 1) s = 7'h00;
		v0 <= 10'($urandom); v1 <= 10'($urandom);
		wr(`OFF_CH_SEL, {25'h0, s}, r);
		wr(`OFF_DAC_CTRL, {29'h0, dc}, r);
		wr(`OFF_EXT_CTRL, {30'h0, ex}, r);
		repeat (3) @(posedge clk);
		chk(src_dac, s);
		chk(src_dac ^ src_pin, 7'h7F);
		chk({path_en, drv}, exp_drv(s, dc, ex, v0, v1));
		chk(pin_en, ex[0]);
		rd(`OFF_CH_SEL, d, r);
		chk(d, {25'h0, s});
		rd(`OFF_STATUS, d, r);
		chk(d, {28'h0, exp_stat(s, dc, ex)});
		rd(`OFF_DAC_VAL, d, r);
		chk(d, {6'h0, v1, 6'h0, v0});
	end
	for (int j = 0; j < 8; j++) begin
		g = 3'(j);
		wr(`OFF_GAIN_LO, {4'h0, {7{1'b0, g}}}, r);
		repeat (3) @(posedge clk);
		for (int k = 0; k < 7; k++) begin
			b = k < 4 ? (g == 3'h4 || g == 3'h7) : (g[2] | &g[1:0]);
			chk(gbad[k], b);
			if (!b) chk(gmul[k], (k < 4 && g == 3'h5) ? 1 : (k < 4 && g == 3'h6) ? 2 : 0);
		end
	end
	wr(32'h10, 32'h1, r);
	chk(r, 2'h2);
	rd(32'h18, d, r);
	chk(r, 2'h2);
	chk(d, 32'h0);
	finish_test();
end
endmodule : testbench
